// ---- logic/bss_pkg.sv ----
`default_nettype none
package bss_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] BSS_ADDR_NORMAL = 8'h35;
  localparam logic [7:0] BSS_ADDR_STBY = 8'h36;
  localparam logic [7:0] BSS_ADDR_SLEEP = 8'h37;
  localparam int BSS_CODE_LSB = 0;
  localparam int BSS_CODE_W = 6;
  localparam int BSS_RANGE_BIT = 6;
  localparam logic [5:0] BSS_CODE_RST = 6'h00;
  localparam logic BSS_RANGE_RST = 1'b0;
  localparam logic [7:0] BSS_RDATA_RST = 8'h00;

  // ==========================================================================
  // voltage coding, in millivolts
  localparam int BSS_MV_W = 12;
  localparam logic [11:0] BSS_LOW_BASE_MV = 12'h190;
  localparam logic [11:0] BSS_LOW_STEP_MV = 12'h019;
  localparam logic [11:0] BSS_HIGH_BASE_MV = 12'h320;
  localparam logic [11:0] BSS_HIGH_STEP_MV = 12'h032;
  localparam logic [5:0] BSS_HIGH_MAX_CODE = 6'h32;
  localparam logic [11:0] BSS_VOUT_RST = 12'h190;

  // ==========================================================================
  // operating modes and phases
  localparam logic [1:0] BSS_MODE_NORMAL = 2'h0;
  localparam logic [1:0] BSS_MODE_STBY = 2'h1;
  localparam logic [1:0] BSS_MODE_SLEEP = 2'h2;

  typedef enum logic {
    BSS_CAPTURE,
    BSS_RUN
  } bss_phase_type;

  typedef struct packed {
    bss_phase_type phase;
    logic range;
    logic [5:0] norm_code;
    logic [5:0] stby_code;
    logic [5:0] sleep_code;
    logic [7:0] rdata;
    logic rvalid;
    logic [5:0] act_code;
    logic act_range;
    logic [11:0] vout;
    logic reserved;
  } bss_state_type;

endpackage
`default_nettype wire

// ---- logic/bss_vout_map.sv ----
`default_nettype none
module bss_vout_map
  import bss_pkg::*;
(
  // set point
  input wire logic [5:0] code_i,
  input wire logic range_i,
  // result
  output logic [11:0] vout_mv_o,
  output logic reserved_o
);

  // ==========================================================================
  // linear mapping
  logic [11:0] code_ext;
  assign code_ext = {6'h00, code_i};
  assign vout_mv_o = range_i ? 12'(BSS_HIGH_BASE_MV + code_ext * BSS_HIGH_STEP_MV)
                             : 12'(BSS_LOW_BASE_MV + code_ext * BSS_LOW_STEP_MV);
  assign reserved_o = range_i && (code_i > BSS_HIGH_MAX_CODE);

endmodule
`default_nettype wire

// ---- logic/bss_setpoint.sv ----
`default_nettype none
module bss_setpoint
  import bss_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // configuration straps
  input wire logic dflt_range_i,
  input wire logic otp_valid_i,
  input wire logic otp_range_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // operating mode
  input wire logic [1:0] op_mode_i,
  // regulator target
  output logic [5:0] active_code_o,
  output logic active_range_o,
  output logic [11:0] vout_mv_o,
  output logic code_reserved_o,
  output logic cfg_done_o
);

  bss_state_type state_ff;
  bss_state_type nxt_state;
  logic [5:0] sel_code;
  logic [11:0] map_mv;
  logic map_reserved;

  // ==========================================================================
  // active set point selection
  always_comb begin
    if (op_mode_i == BSS_MODE_STBY) begin
      sel_code = state_ff.stby_code;
    end else if (op_mode_i == BSS_MODE_SLEEP) begin
      sel_code = state_ff.sleep_code;
    end else begin
      sel_code = state_ff.norm_code;
    end
  end

  bss_vout_map u_map (
    .code_i(sel_code),
    .range_i(state_ff.range),
    .vout_mv_o(map_mv),
    .reserved_o(map_reserved)
  );

  // ==========================================================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rvalid = 1'b0;
    case (state_ff.phase)
      BSS_CAPTURE: begin
        // one range for all three modes, taken once
        nxt_state.range = otp_valid_i ? otp_range_i : dflt_range_i;
        nxt_state.phase = BSS_RUN;
      end
      BSS_RUN: begin
        nxt_state.range = state_ff.range;
      end
      default: begin
        nxt_state.phase = BSS_CAPTURE;
      end
    endcase
    if (reg_wr_i) begin
      // only the code field is writable
      if (reg_addr_i == BSS_ADDR_NORMAL) begin
        nxt_state.norm_code = reg_wdata_i[BSS_CODE_LSB +: BSS_CODE_W];
      end else if (reg_addr_i == BSS_ADDR_STBY) begin
        nxt_state.stby_code = reg_wdata_i[BSS_CODE_LSB +: BSS_CODE_W];
      end else if (reg_addr_i == BSS_ADDR_SLEEP) begin
        nxt_state.sleep_code = reg_wdata_i[BSS_CODE_LSB +: BSS_CODE_W];
      end
    end
    if (reg_rd_i) begin
      nxt_state.rvalid = 1'b1;
      if (reg_addr_i == BSS_ADDR_NORMAL) begin
        nxt_state.rdata = {1'b0, state_ff.range, state_ff.norm_code};
      end else if (reg_addr_i == BSS_ADDR_STBY) begin
        nxt_state.rdata = {1'b0, state_ff.range, state_ff.stby_code};
      end else if (reg_addr_i == BSS_ADDR_SLEEP) begin
        nxt_state.rdata = {1'b0, state_ff.range, state_ff.sleep_code};
      end else begin
        nxt_state.rdata = BSS_RDATA_RST;
      end
    end
    nxt_state.act_code = sel_code;
    nxt_state.act_range = state_ff.range;
    nxt_state.vout = map_mv;
    nxt_state.reserved = map_reserved;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_ff <= '{phase: BSS_CAPTURE, range: BSS_RANGE_RST, norm_code: BSS_CODE_RST,
                    stby_code: BSS_CODE_RST, sleep_code: BSS_CODE_RST,
                    rdata: BSS_RDATA_RST, rvalid: 1'b0, act_code: BSS_CODE_RST,
                    act_range: BSS_RANGE_RST, vout: BSS_VOUT_RST, reserved: 1'b0};
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata_o = state_ff.rdata;
  assign reg_rvalid_o = state_ff.rvalid;
  assign active_code_o = state_ff.act_code;
  assign active_range_o = state_ff.act_range;
  assign vout_mv_o = state_ff.vout;
  assign code_reserved_o = state_ff.reserved;
  assign cfg_done_o = (state_ff.phase == BSS_RUN);

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence normal_write_s;
    clk_en_i && reg_wr_i && reg_addr_i == BSS_ADDR_NORMAL
      && state_ff.phase == BSS_RUN;
  endsequence

  range_read_only_a: assert property (
    normal_write_s |=> state_ff.range == $past(state_ff.range)
      && state_ff.norm_code == $past(reg_wdata_i[5:0]))
    else $error("range bit changed by a register write");

  range_capture_a: assert property (
    state_ff.phase == BSS_CAPTURE && clk_en_i
      |=> state_ff.range == $past(otp_valid_i ? otp_range_i : dflt_range_i)
      && state_ff.phase == BSS_RUN)
    else $error("range not captured from configuration");

  low_range_map_a: assert property (
    !active_range_o |-> vout_mv_o == 12'(BSS_LOW_BASE_MV
      + {6'h00, active_code_o} * BSS_LOW_STEP_MV))
    else $error("low range voltage wrong");

  high_range_map_a: assert property (
    active_range_o |-> vout_mv_o == 12'(BSS_HIGH_BASE_MV
      + {6'h00, active_code_o} * BSS_HIGH_STEP_MV))
    else $error("high range voltage wrong");

  standby_select_a: assert property (
    clk_en_i && op_mode_i == BSS_MODE_STBY
      |=> active_code_o == $past(state_ff.stby_code))
    else $error("standby code not applied");

  sequence stby_read_s;
    clk_en_i && reg_rd_i && reg_addr_i == BSS_ADDR_STBY;
  endsequence

  stby_range_copy_a: assert property (
    stby_read_s |=> reg_rvalid_o && reg_rdata_o[BSS_RANGE_BIT] == $past(state_ff.range)
      && reg_rdata_o[7] == 1'b0)
    else $error("standby range bit differs from normal range");

  reserved_flag_a: assert property (
    code_reserved_o == (active_range_o && active_code_o > BSS_HIGH_MAX_CODE))
    else $error("reserved code flag wrong");

  normal_read_a: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == BSS_ADDR_NORMAL
      |=> reg_rvalid_o && reg_rdata_o == {1'b0, $past(state_ff.range),
      $past(state_ff.norm_code)})
    else $error("normal set point read wrong");

  sequence sleep_read_s;
    clk_en_i && reg_rd_i && reg_addr_i == BSS_ADDR_SLEEP;
  endsequence

  sleep_range_copy_a: assert property (
    sleep_read_s |=> reg_rvalid_o && reg_rdata_o[BSS_RANGE_BIT] == $past(state_ff.range))
    else $error("sleep range bit differs from normal range");

  sleep_select_a: assert property (
    clk_en_i && op_mode_i == BSS_MODE_SLEEP
      |=> active_code_o == $past(state_ff.sleep_code))
    else $error("sleep code not applied");

  sequence norm_mode_s;
    clk_en_i && op_mode_i != BSS_MODE_STBY && op_mode_i != BSS_MODE_SLEEP;
  endsequence

  normal_select_a: assert property (
    norm_mode_s |=> active_code_o == $past(state_ff.norm_code))
    else $error("normal code not applied");

  write_applied_a: assert property (
    normal_write_s ##1 norm_mode_s |=> active_code_o == $past(reg_wdata_i[5:0], 2))
    else $error("written normal code not applied");

  range_hold_a: assert property (
    state_ff.phase == BSS_RUN |=> state_ff.range == $past(state_ff.range))
    else $error("range bit changed after capture");

  cfg_done_hold_a: assert property (
    cfg_done_o |=> cfg_done_o)
    else $error("configuration done dropped without reset");

  rvalid_pulse_a: assert property (
    reg_rvalid_o && clk_en_i && !reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid held longer than one cycle");

endmodule
`default_nettype wire

// ---- dv/bss_setpoint_test.sv ----
`default_nettype none
module bss_setpoint_test
  import bss_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // design hookup
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic dflt_range_i = 1'b0;
  logic otp_valid_i = 1'b0;
  logic otp_range_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 1'b0;
  logic [1:0] op_mode_i = 2'h0;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [5:0] active_code_o;
  logic active_range_o;
  logic [11:0] vout_mv_o;
  logic code_reserved_o;
  logic cfg_done_o;
  int n_fail = 0;
  int tests_run = 0;

  bss_setpoint dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .dflt_range_i(dflt_range_i), .otp_valid_i(otp_valid_i), .otp_range_i(otp_range_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .op_mode_i(op_mode_i), .active_code_o(active_code_o), .active_range_o(active_range_o),
    .vout_mv_o(vout_mv_o), .code_reserved_o(code_reserved_o), .cfg_done_o(cfg_done_o));

  initial forever #20 clock_i = ~clock_i;

  // ==========================================================================
  // access tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic d, input logic ov, input logic orng);
    sys_rst_i = 1'b1;
    dflt_range_i = d;
    otp_valid_i = ov;
    otp_range_i = orng;
    op_mode_i = 2'h0;
    repeat (2) @(negedge clock_i);
    chk("cfg_done", 12'h000, {11'h000, cfg_done_o});
    chk("vout", BSS_VOUT_RST, vout_mv_o);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    @(negedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int i;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    for (i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++) @(negedge clock_i);
    if (i == 4) begin
      chk("rvalid", 12'h001, {11'h000, reg_rvalid_o});
      end_of_test();
    end else chk("rdata", {4'h0, exp}, {4'h0, reg_rdata_o});
    @(negedge clock_i);
    chk("rvalid", 12'h000, {11'h000, reg_rvalid_o});
  endtask

  // applies a mode and compares the regulator target
  task automatic tgt(input logic [1:0] m, input logic [5:0] c, input logic r);
    logic [11:0] e;
    e = r ? BSS_HIGH_BASE_MV + BSS_HIGH_STEP_MV * {6'h00, c}
          : BSS_LOW_BASE_MV + BSS_LOW_STEP_MV * {6'h00, c};
    op_mode_i = m;
    repeat (2) @(negedge clock_i);
    chk("code", {6'h00, c}, {6'h00, active_code_o});
    chk("range", {11'h000, r}, {11'h000, active_range_o});
    chk("vout", e, vout_mv_o);
    chk("reserved", {11'h000, r && c > 6'h32}, {11'h000, code_reserved_o});
  endtask

  // ==========================================================================
  // tests
  initial begin
    do_reset(1'b0, 1'b0, 1'b0);
    chk("cfg_done", 12'h001, {11'h000, cfg_done_o});
    rd(BSS_ADDR_NORMAL, 8'h00);
    wr(BSS_ADDR_NORMAL, 8'hCA);
    rd(BSS_ADDR_NORMAL, 8'h0A);
    wr(BSS_ADDR_STBY, 8'h3F);
    wr(BSS_ADDR_SLEEP, 8'h14);
    wr(8'h38, 8'h11);
    rd(BSS_ADDR_STBY, 8'h3F);
    rd(8'h38, 8'h00);
    tgt(2'h0, 6'h0A, 1'b0);
    tgt(2'h1, 6'h3F, 1'b0);
    tgt(2'h2, 6'h14, 1'b0);
    tgt(2'h3, 6'h0A, 1'b0);
    // a frozen clock enable drops the write
    clk_en_i = 1'b0;
    wr(BSS_ADDR_NORMAL, 8'h0C);
    clk_en_i = 1'b1;
    rd(BSS_ADDR_NORMAL, 8'h0A);
    $display("test low_range done");
    do_reset(1'b0, 1'b1, 1'b1);
    rd(BSS_ADDR_STBY, 8'h40);
    rd(BSS_ADDR_SLEEP, 8'h40);
    wr(BSS_ADDR_NORMAL, 8'h32);
    wr(BSS_ADDR_STBY, 8'h33);
    wr(BSS_ADDR_SLEEP, 8'h18);
    tgt(2'h0, 6'h32, 1'b1);
    tgt(2'h1, 6'h33, 1'b1);
    tgt(2'h2, 6'h18, 1'b1);
    $display("test high_range done");
    do_reset(1'b1, 1'b0, 1'b0);
    dflt_range_i = 1'b0;
    rd(BSS_ADDR_NORMAL, 8'h40);
    wr(BSS_ADDR_NORMAL, 8'hAA);
    rd(BSS_ADDR_NORMAL, 8'h6A);
    $display("test default_strap done");
    end_of_test();
  end
endmodule
`default_nettype wire
